// ---- rtc_timer_consts.vh ----
// constants for the rtc hold/reset and fixed-cycle timer block
// included by rtc_hold_reset_cycle_timer.v; definitions only
`ifndef RTC_TIMER_CONSTS_VH
`define RTC_TIMER_CONSTS_VH

// register word indices, byte address = index << 2 (printed offsets c..f are word indices)
`define REG_TIMER_SETUP 4'hC
`define REG_TIMER_PRESET_LOW 4'hD
`define REG_IRQ_CTRL_FLAGS 4'hE
`define REG_COUNTING_CTRL 4'hF
`define REG_ADDR_SHIFT 2
// own register: time status, word index 10h
`define REG_TIME_STATUS 5'h10

// timer setup fields
`define TS_ENABLE_BIT 7
`define TS_FREQ_OUT_BIT 6
`define TS_SRC_HI_BIT 5
`define TS_SRC_LO_BIT 4
// interrupt control fields
`define IC_REPEAT_BIT 4
`define IC_ALARM_FLAG_BIT 3
`define IC_TIMER_FLAG_BIT 2
`define IC_ALARM_IE_BIT 1
`define IC_TIMER_IE_BIT 0
// counting control fields
`define CC_TEST_BIT 6
`define CC_RESET_BIT 4
`define CC_HOLD_BIT 3

// source selections
`define SRC_4096HZ 2'h0
`define SRC_64HZ 2'h1
`define SRC_1HZ 2'h2
`define SRC_MINUTE 2'h3

// prescaler: 32768 Hz base, 15 stages
`define OSC_HZ 32768
`define PRE_BITS 15
// taps: 4096 Hz = bit 2 rising, 64 Hz = bit 8, 1 Hz = bit 14
`define TAP_4096 2
`define TAP_64 8
`define TAP_1 14
// reset clears 2048 Hz tap (bit 3) through 1 Hz
`define PRE_RESET_MASK 15'h7FF8

// auto release times, ns, and their 32768 Hz tick counts (rounded down)
// counts are given directly: the ns * Hz product overflows 32-bit maths
`define RELEASE_SHORT_NS 122000
`define RELEASE_LONG_NS 7813000
`define RELEASE_SHORT_TICKS 9'h003
`define RELEASE_LONG_TICKS 9'h100

`endif

// ---- rtc_hold_reset_cycle_timer.v ----
// hold/reset control and 12-bit fixed-cycle countdown timer of an rtc,
// as a classic wishbone slave. assumes a 32768 Hz oscillator pin, two
// chip-enable pins, and that calendar counters sit outside.
`timescale 1ns/1ps
`include "rtc_timer_consts.vh"

module rtc_hold_reset_cycle_timer #(
	parameter PRESET_BITS = 12
) (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output wire [31:0] dat_o,
	output reg ack_o,
	input wire osc_i,
	input wire chip_enable_0_i,
	input wire chip_enable_1_i,
	input wire minute_tick_i,
	input wire alarm_match_i,
	input wire freq_output_ctrl_i,
	output reg second_tick_o,
	output reg clock_run_o,
	output reg alarm_run_o,
	output reg event_run_o,
	output reg filter_run_o,
	output reg freq_output_pin_o,
	output reg freq_output_pin_oe_n_o,
	output reg irq_o,
	output reg irq_oe_n_o
);

	function [0:0] rose;
		input a;
		input b;
		rose = a & ~b;
	endfunction

	// three-stage synchronisers for the pin inputs
	reg [2:0] osc_s, ce0_s, ce1_s;
	reg osc_st, ce_low_st;
	always @(posedge clk_i) begin
		if (rst_i) begin
			osc_s <= 3'h0;
			ce0_s <= 3'h7;
			ce1_s <= 3'h7;
			osc_st <= 1'b0;
			ce_low_st <= 1'b0;
		end else begin
			osc_s <= {osc_s[1:0], osc_i};
			ce0_s <= {ce0_s[1:0], chip_enable_0_i};
			ce1_s <= {ce1_s[1:0], chip_enable_1_i};
			if (osc_s[1] == osc_s[2])
				osc_st <= osc_s[2];
			if ((ce0_s[1] == ce0_s[2]) && (ce1_s[1] == ce1_s[2]))
				ce_low_st <= ~ce0_s[2] | ~ce1_s[2];
		end
	end
	reg osc_prev, ce_low_prev;
	wire osc_edge = rose(osc_st, osc_prev);
	wire ce_fall = rose(ce_low_st, ce_low_prev);

	// registers
	reg [7:0] timer_setup, timer_preset_low;
	reg repeat_mode_select, alarm_event_flag, timer_event_flag;
	reg alarm_irq_enable, timer_irq_enable;
	reg test_bit, reset_bit, hold_bit;
	wire countdown_enable = timer_setup[`TS_ENABLE_BIT];
	wire [1:0] src_sel = {timer_setup[`TS_SRC_HI_BIT], timer_setup[`TS_SRC_LO_BIT]};
	wire [PRESET_BITS-1:0] preset = {timer_setup[3:0], timer_preset_low};

	// wishbone decode
	wire [5:0] word = adr_i[7:`REG_ADDR_SHIFT];
	wire acc = cyc_i & stb_i & ~ack_o;
	wire wr = acc & we_i & sel_i[0];
	wire wr_setup = wr && (word == {2'h0, `REG_TIMER_SETUP});
	wire wr_low = wr && (word == {2'h0, `REG_TIMER_PRESET_LOW});
	wire wr_flags = wr && (word == {2'h0, `REG_IRQ_CTRL_FLAGS});
	wire wr_ctrl = wr && (word == {2'h0, `REG_COUNTING_CTRL});

	// prescaler and dedicated timer 1 Hz divider
	reg [`PRE_BITS-1:0] pre, tdiv;
	wire [`PRE_BITS-1:0] pre_inc = pre + 15'h0001;
	wire [`PRE_BITS-1:0] tdiv_inc = tdiv + 15'h0001;
	wire tick_4096 = osc_edge & rose(pre_inc[`TAP_4096], pre[`TAP_4096]);
	wire tick_64 = osc_edge & rose(pre_inc[`TAP_64], pre[`TAP_64]);
	wire sec_raw = osc_edge & rose(pre_inc[`TAP_1], pre[`TAP_1]);
	wire tick_1 = osc_edge & rose(tdiv_inc[`TAP_1], tdiv[`TAP_1]);

	// timer runs per hold/reset and source
	wire timer_run = reset_bit ? (src_sel == `SRC_4096HZ)
		: ~(hold_bit && (src_sel == `SRC_MINUTE));
	reg src_tick;
	always @* begin
		case (src_sel)
			`SRC_4096HZ: src_tick = tick_4096;
			`SRC_64HZ: src_tick = tick_64;
			`SRC_1HZ: src_tick = tick_1;
			default: src_tick = minute_tick_i;
		endcase
	end

	// countdown
	reg [PRESET_BITS-1:0] count;
	reg en_prev;
	reg [8:0] rel_cnt;
	wire start = rose(countdown_enable, en_prev);
	wire fire = countdown_enable & ~start & timer_run & src_tick
		&& (count == {{(PRESET_BITS-1){1'b0}}, 1'b1});
	reg pending, hold_seen_acc;
	always @(posedge clk_i) begin
		if (rst_i) begin
			osc_prev <= 1'b0;
			ce_low_prev <= 1'b0;
			pre <= 15'h0000;
			tdiv <= 15'h0000;
			timer_setup <= 8'h00;
			timer_preset_low <= 8'h00;
			repeat_mode_select <= 1'b0;
			alarm_event_flag <= 1'b0;
			timer_event_flag <= 1'b0;
			alarm_irq_enable <= 1'b0;
			timer_irq_enable <= 1'b0;
			test_bit <= 1'b0;
			reset_bit <= 1'b0;
			hold_bit <= 1'b0;
			count <= {PRESET_BITS{1'b0}};
			en_prev <= 1'b0;
			rel_cnt <= 9'h000;
			pending <= 1'b0;
			hold_seen_acc <= 1'b0;
			second_tick_o <= 1'b0;
			irq_o <= 1'b0;
			irq_oe_n_o <= 1'b1;
		end else begin
			osc_prev <= osc_st;
			ce_low_prev <= ce_low_st;
			en_prev <= countdown_enable;
			// reset clears 2048 Hz..1 Hz stages
			// low stages keep the oscillator rate so 4096 Hz ticks stay true
			if (reset_bit) begin
				if (osc_edge) begin
					pre <= pre_inc & ~`PRE_RESET_MASK;
					tdiv <= tdiv_inc & ~`PRE_RESET_MASK;
				end else begin
					pre <= pre & ~`PRE_RESET_MASK;
					tdiv <= tdiv & ~`PRE_RESET_MASK;
				end
			end else if (osc_edge) begin
				pre <= pre_inc;
				tdiv <= tdiv_inc;
			end
			if (wr_setup)
				timer_setup <= dat_i[7:0];
			if (wr_low)
				timer_preset_low <= dat_i[7:0];
			if (wr_flags) begin
				repeat_mode_select <= dat_i[`IC_REPEAT_BIT];
				alarm_irq_enable <= dat_i[`IC_ALARM_IE_BIT];
				timer_irq_enable <= dat_i[`IC_TIMER_IE_BIT];
			end
			// set wins over a clear in the same cycle; writing one is ignored
			if (fire)
				timer_event_flag <= 1'b1;
			else if (wr_flags && !dat_i[`IC_TIMER_FLAG_BIT])
				timer_event_flag <= 1'b0;
			if (alarm_match_i && alarm_run_o)
				alarm_event_flag <= 1'b1;
			else if (wr_flags && !dat_i[`IC_ALARM_FLAG_BIT])
				alarm_event_flag <= 1'b0;
			if (wr_ctrl) begin
				test_bit <= dat_i[`CC_TEST_BIT];
				reset_bit <= dat_i[`CC_RESET_BIT];
				hold_bit <= dat_i[`CC_HOLD_BIT];
			end
			// chip enable low clears test and reset
			if (ce_fall) begin
				test_bit <= 1'b0;
				reset_bit <= 1'b0;
			end
			// reload while disabled or on start
			if (!countdown_enable || start)
				count <= preset;
			else if (fire) begin
				count <= preset;
				if (!repeat_mode_select)
					timer_setup[`TS_ENABLE_BIT] <= 1'b0;
			end else if (timer_run && src_tick && count != {PRESET_BITS{1'b0}})
				count <= count - {{(PRESET_BITS-1){1'b0}}, 1'b1};
			// one pending second while frozen, at most one
			second_tick_o <= 1'b0;
			if (sec_raw && !reset_bit) begin
				if (hold_bit || hold_seen_acc)
					pending <= 1'b1;
				else
					second_tick_o <= 1'b1;
			end else if (pending && !hold_bit && !hold_seen_acc) begin
				second_tick_o <= 1'b1;
				pending <= 1'b0;
			end
			// keep frozen until write access finishes
			hold_seen_acc <= hold_bit & acc & we_i;
			// auto release pulse in repeated mode
			if (fire && repeat_mode_select)
				rel_cnt <= (src_sel == `SRC_4096HZ) ? `RELEASE_SHORT_TICKS
					: `RELEASE_LONG_TICKS;
			else if (rel_cnt != 9'h000 && osc_edge)
				rel_cnt <= rel_cnt - 9'h001;
			irq_o <= 1'b0;
			irq_oe_n_o <= ~((timer_irq_enable && (repeat_mode_select ?
				(rel_cnt != 9'h000) : timer_event_flag))
				|| (alarm_irq_enable && alarm_event_flag));
		end
	end

	// run enables for the surrounding functions
	always @(posedge clk_i) begin
		if (rst_i) begin
			clock_run_o <= 1'b1;
			alarm_run_o <= 1'b1;
			event_run_o <= 1'b1;
			filter_run_o <= 1'b1;
			freq_output_pin_o <= 1'b0;
			freq_output_pin_oe_n_o <= 1'b1;
		end else begin
			clock_run_o <= ~reset_bit & ~hold_bit;
			alarm_run_o <= ~reset_bit & ~hold_bit;
			event_run_o <= ~reset_bit;
			filter_run_o <= ~reset_bit;
			freq_output_pin_o <= osc_st;
			freq_output_pin_oe_n_o <= ~(timer_setup[`TS_FREQ_OUT_BIT] | freq_output_ctrl_i);
		end
	end

	// reads show the preset, not the live count
	reg [7:0] rd;
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			rd <= 8'h00;
		end else begin
			ack_o <= acc;
			case (word)
				{2'h0, `REG_TIMER_SETUP}: rd <= timer_setup;
				{2'h0, `REG_TIMER_PRESET_LOW}: rd <= timer_preset_low;
				{2'h0, `REG_IRQ_CTRL_FLAGS}: rd <= {3'h0, repeat_mode_select,
					alarm_event_flag, timer_event_flag, alarm_irq_enable, timer_irq_enable};
				{2'h0, `REG_COUNTING_CTRL}: rd <= {1'b0, test_bit, 1'b0, reset_bit,
					hold_bit, 3'h0};
				{1'b0, `REG_TIME_STATUS}: rd <= {5'h00, pending, countdown_enable, clock_run_o};
				default: rd <= 8'h00;
			endcase
		end
	end
	assign dat_o = {24'h000000, rd};

endmodule // rtc_hold_reset_cycle_timer

// ---- rtc_timer_asserts.sv ----
// port checker for the rtc countdown timer block
// assumes one clock domain and the bind at the foot
`timescale 1ns/1ps
module rtc_timer_asserts (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire ack_o,
	input wire [31:0] dat_o,
	input wire irq_o,
	input wire irq_oe_n_o,
	input wire freq_output_ctrl_i,
	input wire freq_output_pin_oe_n_o,
	input wire clock_run_o,
	input wire alarm_run_o,
	input wire event_run_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_answer;
		ack_o ##1 !ack_o;
	endsequence
	a_ack_follows: assert property (s_take |=> s_answer)
		else $error("ack not one cycle after request");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_dat_upper: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	a_irq_data_low: assert property (irq_o == 1'b0)
		else $error("irq data not low");
	a_freq_drive: assert property (freq_output_ctrl_i |-> ##[0:6] !freq_output_pin_oe_n_o)
		else $error("freq output not driven");
	a_alarm_stop: assert property (!clock_run_o |-> !alarm_run_o)
		else $error("alarm runs while clock stopped");
	a_event_stop: assert property (!event_run_o |-> !clock_run_o)
		else $error("events stopped while clock runs");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && irq_oe_n_o)
		else $error("outputs active after reset");
endmodule // rtc_timer_asserts

bind rtc_hold_reset_cycle_timer rtc_timer_asserts chk (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o), .irq_o(irq_o),
	.irq_oe_n_o(irq_oe_n_o), .freq_output_ctrl_i(freq_output_ctrl_i),
	.freq_output_pin_oe_n_o(freq_output_pin_oe_n_o), .clock_run_o(clock_run_o),
	.alarm_run_o(alarm_run_o), .event_run_o(event_run_o));

// ---- rtc_env_model.sv ----
// oscillator and calendar minute source for the timer block
// assumes clk_i; oscillator far faster than real to keep runs short
`timescale 1ns/1ps
module rtc_env_model #(
	parameter HALF = 4,
	parameter MINUTE = 600
) (
	input wire clk_i,
	output reg osc_o,
	output reg minute_tick_o
);
	integer div = 0;
	integer mcnt = 0;
	initial osc_o = 1'b0;
	initial minute_tick_o = 1'b0;
	always @(posedge clk_i) begin
		div <= (div == HALF - 1) ? 0 : div + 1;
		if (div == HALF - 1)
			osc_o <= ~osc_o;
		mcnt <= (mcnt == MINUTE - 1) ? 0 : mcnt + 1;
		minute_tick_o <= (mcnt == MINUTE - 1);
	end
endmodule // rtc_env_model

// ---- testbench.sv ----
// self-checking bench for the rtc hold/reset and countdown timer
// assumes the oscillator model runs at one eighth of the clock rate
`timescale 1ns/1ps
module testbench;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg cyc = 1'b0, stb = 1'b0, we = 1'b0, ce0 = 1'b1;
	reg [7:0] adr = 8'h00;
	reg [31:0] wdat = 32'h00000000, q;
	wire [31:0] rdat;
	wire ack, osc, minute_tick, irq_oe_n, clock_run;
	integer n_errors = 0, compares = 0, n;
	rtc_env_model env (.clk_i(clk_i), .osc_o(osc), .minute_tick_o(minute_tick));
	rtc_hold_reset_cycle_timer uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.osc_i(osc), .chip_enable_0_i(ce0), .chip_enable_1_i(1'b1),
		.minute_tick_i(minute_tick), .alarm_match_i(1'b0), .freq_output_ctrl_i(1'b1),
		.second_tick_o(), .clock_run_o(clock_run), .alarm_run_o(), .event_run_o(),
		.filter_run_o(), .freq_output_pin_o(), .freq_output_pin_oe_n_o(), .irq_o(),
		.irq_oe_n_o(irq_oe_n));
	initial forever #4 clk_i = ~clk_i;
	task end_sim;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares = compares + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task acc(input logic [7:0] a, input logic w, input logic [7:0] d);
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 40) begin
			@(posedge clk_i);
			n = n + 1;
		end
		if (n == 40)
			n_errors = n_errors + 1;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		acc(a, 1'b1, d);
	endtask
	task rd(input string what, input logic [7:0] a, input logic [7:0] e);
		acc(a, 1'b0, 8'h00);
		chk(what, {24'h000000, e}, q);
	endtask
	task wait_irq(input logic lvl);
		n = 0;
		while (irq_oe_n !== lvl && n < 5000) begin
			@(posedge clk_i);
			n = n + 1;
		end
		if (n == 5000)
			n_errors = n_errors + 1;
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("irq idle", 1, irq_oe_n);
		wr(8'h38, 8'h01);
		wr(8'h34, 8'h02);
		wr(8'h30, 8'h80);
		wait_irq(1'b0);
		chk("irq single", 0, irq_oe_n);
		rd("setup", 8'h30, 8'h00);
		rd("preset low", 8'h34, 8'h02);
		rd("flags", 8'h38, 8'h05);
		repeat (100) @(posedge clk_i);
		chk("irq held", 0, irq_oe_n);
		wr(8'h38, 8'h01);
		repeat (2) @(posedge clk_i);
		chk("irq cancelled", 1, irq_oe_n);
		wr(8'h38, 8'h11);
		wr(8'h30, 8'h80);
		wait_irq(1'b0);
		wait_irq(1'b1);
		chk("short release", 1, n > 15 && n < 41);
		wait_irq(1'b0);
		chk("repeat fire", 0, irq_oe_n);
		rd("setup running", 8'h30, 8'h80);
		wr(8'h30, 8'h00);
		wait_irq(1'b1);
		chk("pulse ended", 1, irq_oe_n);
		wr(8'h34, 8'h01);
		wr(8'h30, 8'h90);
		wait_irq(1'b0);
		wait_irq(1'b1);
		chk("long release", 1, n > 1990 && n < 2110);
		wr(8'h30, 8'h0F);
		rd("setup preset", 8'h30, 8'h0F);
		wr(8'h34, 8'hFF);
		rd("preset max", 8'h34, 8'hFF);
		wr(8'h3C, 8'h50);
		repeat (4) @(posedge clk_i);
		chk("clock stopped", 0, clock_run);
		rd("control", 8'h3C, 8'h50);
		ce0 <= 1'b0;
		repeat (4) @(posedge clk_i);
		ce0 <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd("control deselect", 8'h3C, 8'h00);
		chk("clock running", 1, clock_run);
		wr(8'h3C, 8'h10);
		wr(8'h3C, 8'h00);
		rd("control cleared", 8'h3C, 8'h00);
		wr(8'h3C, 8'h08);
		repeat (4) @(posedge clk_i);
		chk("clock held", 0, clock_run);
		wr(8'h3C, 8'h00);
		repeat (4) @(posedge clk_i);
		chk("clock resumed", 1, clock_run);
		rd("unmapped", 8'h80, 8'h00);
		end_sim;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors = n_errors + 1;
		end_sim;
	end
endmodule // testbench
